// [rtl/pfm_consts.svh]
// Constants for the port 2 / port 3 pin function mux: offsets, reset values.
// Assumes a byte-wide register port carrying 8-bit data.
`ifndef PFM_CONSTS_SVH
`define PFM_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PFM_ADDR_W          4
`define PFM_OFF_P2_IN       4'h0
`define PFM_OFF_P2_OUT      4'h1
`define PFM_OFF_P2_DIR      4'h2
`define PFM_OFF_P2_IFG      4'h3
`define PFM_OFF_P2_IES      4'h4
`define PFM_OFF_P2_IE       4'h5
`define PFM_OFF_P2_SEL      4'h6
`define PFM_OFF_P3_IN       4'h8
`define PFM_OFF_P3_OUT      4'h9
`define PFM_OFF_P3_DIR      4'ha
`define PFM_OFF_P3_SEL      4'hb
`define PFM_OFF_SER_MODE    4'hc

// ****************************************
// Reset values and field positions
// ****************************************
`define PFM_RST_BYTE        8'h00
`define PFM_RST_MODE        2'h0
`define PFM_BIT_SCLK        3
`define PFM_P2_SOFT_MASK    8'hc0

`endif

// [rtl/pfm_pkg.sv]
// Types for the pin function mux.
// Assumes nothing beyond the constants header.
package pfm_pkg;
    // Serial unit mode as seen by the shift clock pin
    typedef enum logic [1:0] {
        PFM_SER_ASYNC    = 2'h0,
        PFM_SER_SYNC_SLV = 2'h1,
        PFM_SER_SYNC_MST = 2'h2
    } pfm_ser_mode_t;
endpackage

// [rtl/pfm_port_mux.sv]
// Pin function mux for two 8-bit ports with port 2 edge interrupts.
// Assumes a single sys_clk domain; pins arrive asynchronously.
// Peripheral outputs share sys_clk; every output leaves from a flip-flop.
//
// Functional notes
// - Port 2 bit 0 selected drives auxiliary clock; direction from port direction bit.
// - Port 2 bit 1 selected outputs low; pin feeds timer alternate clock.
// - Port 2 bit 2 selected drives comparator result; pin feeds capture 0 alt input.
// - Port 2 bits 3, 4 selected drive timer output units 1 and 2.
// - Port 2 bits 6, 7 have no pin, output low, keep all control bits.
// - Unbonded port 2 flags change only by software and raise the port interrupt.
// - Every port 2 bit has enable, flag and edge-select bits plus the rest.
// - Port 3 bit 0 selected is input, low out, feeds slave transmit enable.
// - Port 3 bit 4 selected is forced output driving serial transmit data.
// - Port 3 bit 5 selected is input, low out, feeds serial receive data.
// - Port 3 bits 6, 7 selected are inputs with low out, unconnected.
// - Asynchronous mode with clock function selected keeps shift clock pin input.
// - Synchronous master mode drives the shift clock out on its pin.
`timescale 1ns/1ps
`include "pfm_consts.svh"

module pfm_port_mux #(
    parameter int WIDTH = 8
) (
    input  wire logic                   sys_clk,
    input  wire logic                   nrst,
    input  wire logic [`PFM_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    output logic                        port2_irq,
    input  wire logic [5:0]             port2_pin_in,
    output logic      [5:0]             port2_pin_out,
    output logic      [5:0]             port2_pin_oe,
    input  wire logic [WIDTH-1:0]       port3_pin_in,
    output logic      [WIDTH-1:0]       port3_pin_out,
    output logic      [WIDTH-1:0]       port3_pin_oe,
    input  wire logic                   aux_clock,
    input  wire logic                   comparator_result,
    input  wire logic                   timer_output_unit1,
    input  wire logic                   timer_output_unit2,
    input  wire logic                   serial_transmit_data,
    input  wire logic                   serial_shift_clock_out,
    output logic                        timer_alternate_clock_in,
    output logic                        timer_capture0_alt_input,
    output logic                        slave_transmit_enable,
    output logic                        serial_receive_data,
    output logic                        serial_shift_clock_in
);

    // Structure is fixed to the 8-bit ports
    initial begin
        if (WIDTH != 8) begin
            $error("pfm_port_mux supports WIDTH of 8 only");
        end
        if (`PFM_BIT_SCLK >= WIDTH) begin
            $error("pfm_port_mux shift clock bit lies outside port 3");
        end
        if (`PFM_ADDR_W < 4) begin
            $error("pfm_port_mux offsets need four address bits");
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] port2_function_select_ff;
    logic [7:0] port2_direction_ff;
    logic [7:0] port2_output_latch_ff;
    logic [7:0] port2_irq_enable_ff;
    logic [7:0] port2_irq_flag_ff;
    logic [7:0] port2_irq_edge_select_ff;
    logic [7:0] port3_function_select_ff;
    logic [7:0] port3_direction_ff;
    logic [7:0] port3_output_latch_ff;
    logic [1:0] ser_mode_ff;
    logic [7:0] p2_s1_ff, p2_s2_ff, p2_s3_ff, port2_input_value_ff;
    logic [7:0] p3_s1_ff, p3_s2_ff, p3_s3_ff, port3_input_value_ff;
    logic [7:0] p2_prev_ff;
    logic [7:0] p2_edge;
    logic [7:0] nxt_port2_irq_flag;
    logic [7:0] nxt_rdata;
    logic [7:0] nxt_p2_out, nxt_p2_oe;
    logic [7:0] nxt_p3_out, nxt_p3_oe;
    logic [7:0] p2_mod_out, p3_mod_out, p3_mod_dir_val, p3_mod_dir_en;
    logic       sclk_is_input;
    logic [7:0] nxt_port2_irq_enable;

    wire wr2 = reg_wr;

    // Software-written control bits; flags handled separately
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            port2_function_select_ff <= `PFM_RST_BYTE;
            port2_direction_ff       <= `PFM_RST_BYTE;
            port2_output_latch_ff    <= `PFM_RST_BYTE;
            port2_irq_enable_ff      <= `PFM_RST_BYTE;
            port2_irq_edge_select_ff <= `PFM_RST_BYTE;
            port3_function_select_ff <= `PFM_RST_BYTE;
            port3_direction_ff       <= `PFM_RST_BYTE;
            port3_output_latch_ff    <= `PFM_RST_BYTE;
            ser_mode_ff              <= `PFM_RST_MODE;
        end else if (wr2) begin
            unique case (reg_addr)
                `PFM_OFF_P2_OUT:   port2_output_latch_ff    <= reg_wdata;
                `PFM_OFF_P2_DIR:   port2_direction_ff       <= reg_wdata;
                `PFM_OFF_P2_IES:   port2_irq_edge_select_ff <= reg_wdata;
                `PFM_OFF_P2_IE:    port2_irq_enable_ff      <= reg_wdata;
                `PFM_OFF_P2_SEL:   port2_function_select_ff <= reg_wdata;
                `PFM_OFF_P3_OUT:   port3_output_latch_ff    <= reg_wdata;
                `PFM_OFF_P3_DIR:   port3_direction_ff       <= reg_wdata;
                `PFM_OFF_P3_SEL:   port3_function_select_ff <= reg_wdata;
                `PFM_OFF_SER_MODE: ser_mode_ff              <= reg_wdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Pin input synchronisers
    // ****************************************
    // Three stages; a change counts only once stages two and three agree
    // Stage one is read by stage two only, never by other logic.
    // Hazard: edge history resets low, so a pin held high through reset
    // flags a rising edge shortly after release.
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            p2_s1_ff             <= `PFM_RST_BYTE;
            p2_s2_ff             <= `PFM_RST_BYTE;
            p2_s3_ff             <= `PFM_RST_BYTE;
            port2_input_value_ff <= `PFM_RST_BYTE;
            p3_s1_ff             <= `PFM_RST_BYTE;
            p3_s2_ff             <= `PFM_RST_BYTE;
            p3_s3_ff             <= `PFM_RST_BYTE;
            port3_input_value_ff <= `PFM_RST_BYTE;
            p2_prev_ff           <= `PFM_RST_BYTE;
        end else begin
            // Unbonded bits 6, 7 have no pin and read as zero
            p2_s1_ff   <= {2'h0, port2_pin_in};
            p2_s2_ff   <= p2_s1_ff;
            p2_s3_ff   <= p2_s2_ff;
            p3_s1_ff   <= port3_pin_in;
            p3_s2_ff   <= p3_s1_ff;
            p3_s3_ff   <= p3_s2_ff;
            port2_input_value_ff <= (p2_s2_ff & p2_s3_ff) | (port2_input_value_ff
                                    & ~(p2_s2_ff ^ p2_s3_ff) & p2_s2_ff) |
                                    (port2_input_value_ff & (p2_s2_ff ^ p2_s3_ff));
            port3_input_value_ff <= (p3_s2_ff & p3_s3_ff) |
                                    (port3_input_value_ff & (p3_s2_ff ^ p3_s3_ff));
            p2_prev_ff <= port2_input_value_ff;
        end
    end

    // ****************************************
    // Port 2 interrupt flags
    // ****************************************
    // Edge select 0 catches rising, 1 falling; unbonded bits never see an edge
    always_comb begin
        p2_edge = (~port2_irq_edge_select_ff & ~p2_prev_ff & port2_input_value_ff) |
                  (port2_irq_edge_select_ff & p2_prev_ff & ~port2_input_value_ff);
        p2_edge = p2_edge & ~`PFM_P2_SOFT_MASK;
        nxt_port2_irq_flag = port2_irq_flag_ff;
        if (wr2 && reg_addr == `PFM_OFF_P2_IFG) begin
            nxt_port2_irq_flag = reg_wdata;
        end
        // A pin edge in the cycle of a clearing write still sets its flag
        nxt_port2_irq_flag = nxt_port2_irq_flag | p2_edge;
        // Enable as written this cycle, so the level never lags a mask change
        nxt_port2_irq_enable = port2_irq_enable_ff;
        if (wr2 && reg_addr == `PFM_OFF_P2_IE) begin
            nxt_port2_irq_enable = reg_wdata;
        end
    end

    // Sticky flags; only a write replaces them
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            port2_irq_flag_ff <= `PFM_RST_BYTE;
        end else begin
            port2_irq_flag_ff <= nxt_port2_irq_flag;
        end
    end

    // ****************************************
    // Port 2 interrupt output
    // ****************************************
    // Level output, including software-set unbonded flags
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            port2_irq <= 1'b0;
        end else begin
            port2_irq <= |(nxt_port2_irq_flag & nxt_port2_irq_enable);
        end
    end

    // ****************************************
    // Output function mux
    // ****************************************
    // Port 2 map when selected:
    //   bit 0 auxiliary clock out, bit 1 low out with pin to timer clock,
    //   bit 2 comparator out with pin to capture input, bits 3/4 timer units,
    //   bit 5 low out, bits 6/7 low out with no pin at all.
    // Port 2 direction is never taken over by a peripheral.
    // Port 3 map when selected:
    //   bit 0 slave enable in, bits 1/2 low out under software direction,
    //   bit 3 shift clock, bit 4 transmit out, bit 5 receive in, bits 6/7 idle in.
    // Forced inputs other than shift clock bit 3 also carry a low value, so the output latch never
    // leaks onto a pin that belongs to a listening peripheral.
    always_comb begin
        p2_mod_out    = {2'h0, 1'b0, timer_output_unit2, timer_output_unit1,
                         comparator_result, 1'b0, aux_clock};
        p3_mod_out    = 8'h00;
        p3_mod_out[4] = serial_transmit_data;
        p3_mod_out[`PFM_BIT_SCLK] = serial_shift_clock_out;
        // Forced directions: bit 4 out, 0/5/6/7 in, bit 3 by serial mode; bits 1, 2 follow direction
        p3_mod_dir_en  = 8'hf1;
        p3_mod_dir_val = 8'h10;
        // Mode 3 is unused and treated as a listening clock pin
        sclk_is_input = (pfm_pkg::pfm_ser_mode_t'(ser_mode_ff) != pfm_pkg::PFM_SER_SYNC_MST);
        if (port3_function_select_ff[`PFM_BIT_SCLK]) begin
            p3_mod_dir_en[`PFM_BIT_SCLK]  = 1'b1;
            p3_mod_dir_val[`PFM_BIT_SCLK] = ~sclk_is_input;
        end
        // Port 2 direction always follows the direction bits
        nxt_p2_out = (port2_function_select_ff & p2_mod_out) |
                     (~port2_function_select_ff & port2_output_latch_ff);
        nxt_p2_oe  = port2_direction_ff;
        nxt_p3_out = (port3_function_select_ff & p3_mod_out) |
                     (~port3_function_select_ff & port3_output_latch_ff);
        nxt_p3_oe  = (port3_function_select_ff & p3_mod_dir_en & p3_mod_dir_val) |
                     (~(port3_function_select_ff & p3_mod_dir_en) & port3_direction_ff);
    end

    // Registered pins and module inputs; one cycle of latency traded for clean outputs
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            port2_pin_out            <= 6'h00;
            port2_pin_oe             <= 6'h00;
            port3_pin_out            <= `PFM_RST_BYTE;
            port3_pin_oe             <= `PFM_RST_BYTE;
            timer_alternate_clock_in <= 1'b0;
            timer_capture0_alt_input <= 1'b0;
            slave_transmit_enable    <= 1'b0;
            serial_receive_data      <= 1'b0;
            serial_shift_clock_in    <= 1'b0;
        end else begin
            port2_pin_out <= nxt_p2_out[5:0];
            port2_pin_oe  <= nxt_p2_oe[5:0];
            port3_pin_out <= nxt_p3_out;
            port3_pin_oe  <= nxt_p3_oe;
            // Module inputs see the pin only while the function is selected
            timer_alternate_clock_in <= port2_function_select_ff[1] &
                                        port2_input_value_ff[1];
            timer_capture0_alt_input <= port2_function_select_ff[2] &
                                        port2_input_value_ff[2];
            slave_transmit_enable    <= port3_function_select_ff[0] &
                                        port3_input_value_ff[0];
            serial_receive_data      <= port3_function_select_ff[5] &
                                        port3_input_value_ff[5];
            serial_shift_clock_in    <= port3_function_select_ff[`PFM_BIT_SCLK] &
                                        sclk_is_input &
                                        port3_input_value_ff[`PFM_BIT_SCLK];
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Unmapped offsets read as zero; input registers are read-only
    always_comb begin
        unique case (reg_addr)
            `PFM_OFF_P2_IN:    nxt_rdata = port2_input_value_ff;
            `PFM_OFF_P2_OUT:   nxt_rdata = port2_output_latch_ff;
            `PFM_OFF_P2_DIR:   nxt_rdata = port2_direction_ff;
            `PFM_OFF_P2_IFG:   nxt_rdata = port2_irq_flag_ff;
            `PFM_OFF_P2_IES:   nxt_rdata = port2_irq_edge_select_ff;
            `PFM_OFF_P2_IE:    nxt_rdata = port2_irq_enable_ff;
            `PFM_OFF_P2_SEL:   nxt_rdata = port2_function_select_ff;
            `PFM_OFF_P3_IN:    nxt_rdata = port3_input_value_ff;
            `PFM_OFF_P3_OUT:   nxt_rdata = port3_output_latch_ff;
            `PFM_OFF_P3_DIR:   nxt_rdata = port3_direction_ff;
            `PFM_OFF_P3_SEL:   nxt_rdata = port3_function_select_ff;
            `PFM_OFF_SER_MODE: nxt_rdata = {6'h00, ser_mode_ff};
            default:           nxt_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    // and is zero otherwise, so a late sample never sees stale data
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            reg_rdata <= `PFM_RST_BYTE;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
        end
    end

endmodule

// [tb/pfm_pin_model.sv]
// Far-side model: external pin drivers behind both ports.
// Assumes the bench supplies the external levels.
`timescale 1ns/1ps
module pfm_pin_model (
    input  wire logic [5:0] p2_out,
    input  wire logic [5:0] p2_oe,
    input  wire logic [5:0] p2_ext,
    input  wire logic [7:0] p3_out,
    input  wire logic [7:0] p3_oe,
    input  wire logic [7:0] p3_ext,
    output logic      [5:0] p2_in,
    output logic      [7:0] p3_in
);
    // Device drive wins; a released pin shows the outside source
    assign p2_in = (p2_oe & p2_out) | (~p2_oe & p2_ext);
    // Shift clock pin 3 carries the outside master's clock when released
    assign p3_in = (p3_oe & p3_out) | (~p3_oe & p3_ext);
endmodule

// [tb/pfm_port_mux_chk.sv]
// Checker for the pin function mux, watching top-level ports only.
// Assumes it is bound onto pfm_port_mux.
`timescale 1ns/1ps
`include "pfm_consts.svh"
module pfm_port_mux_chk #(
    parameter int WIDTH = 8
) (
    input wire logic                   sys_clk,
    input wire logic                   nrst,
    input wire logic [`PFM_ADDR_W-1:0] reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire logic [5:0]             port2_pin_in,
    input wire logic [5:0]             port2_pin_out,
    input wire logic [WIDTH-1:0]       port3_pin_out,
    input wire logic [WIDTH-1:0]       port3_pin_oe,
    input wire logic                   aux_clock,
    input wire logic                   comparator_result,
    input wire logic                   timer_output_unit1,
    input wire logic                   timer_output_unit2,
    input wire logic                   serial_transmit_data,
    input wire logic                   serial_shift_clock_out,
    input wire logic                   timer_alternate_clock_in
);
    logic [7:0] p2s_ff;
    logic [7:0] p3s_ff;
    logic [1:0] md_ff;
    // Shadow of select and mode writes; reads never change them
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            p2s_ff <= 8'h00;
            p3s_ff <= 8'h00;
            md_ff  <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == `PFM_OFF_P2_SEL) p2s_ff <= reg_wdata;
            if (reg_addr == `PFM_OFF_P3_SEL) p3s_ff <= reg_wdata;
            if (reg_addr == `PFM_OFF_SER_MODE) md_ff <= reg_wdata[1:0];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    aux_drive_a: assert property (p2s_ff[0] && $past(p2s_ff[0])
        |-> port2_pin_out[0] == $past(aux_clock)) else $error("aux clock not on pin");
    cmp_drive_a: assert property (p2s_ff[2] && $past(p2s_ff[2])
        |-> port2_pin_out[2] == $past(comparator_result)) else $error("comparator not on pin");
    tmr_drive_a: assert property (p2s_ff[3] && $past(p2s_ff[3])
        |-> port2_pin_out[3] == $past(timer_output_unit1)) else $error("timer unit not on pin");
    low_out_a: assert property ((port2_pin_out & p2s_ff[5:0] & $past(p2s_ff[5:0])
        & 6'h22) == 6'h00) else $error("function output not low");
    txd_drive_a: assert property (p3s_ff[4] && $past(p3s_ff[4]) |-> port3_pin_oe[4]
        && port3_pin_out[4] == $past(serial_transmit_data)) else $error("transmit pin wrong");
    in_force_a: assert property (((port3_pin_oe | port3_pin_out) & p3s_ff
        & $past(p3s_ff) & 8'he1) == 8'h00) else $error("input function driven");
    sclk_dir_a: assert property (p3s_ff[3] && $past(p3s_ff[3]) && md_ff == $past(md_ff)
        |-> port3_pin_oe[3] == (md_ff == 2'h2)) else $error("shift clock direction");
    sclk_out_a: assert property (p3s_ff[3] && $past(p3s_ff[3]) && md_ff == 2'h2
        |-> port3_pin_out[3] == $past(serial_shift_clock_out)) else $error("shift clock out");
    alt_clk_a: assert property (timer_alternate_clock_in |-> $past(port2_pin_in[1], 4)
        || $past(port2_pin_in[1], 5) || $past(port2_pin_in[1], 6)) else $error("alt clock");
endmodule
bind pfm_port_mux pfm_port_mux_chk #(.WIDTH(WIDTH)) i_chk (.sys_clk, .nrst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port2_pin_in, .port2_pin_out, .port3_pin_out,
    .port3_pin_oe, .aux_clock, .comparator_result, .timer_output_unit1, .timer_output_unit2,
    .serial_transmit_data, .serial_shift_clock_out, .timer_alternate_clock_in);

// [tb/port2_port3_pin_function_mux_tb_top.sv]
// Self-checking bench for the pin function mux.
// Assumes the pin model and a bound checker.
`timescale 1ns/1ps
`include "pfm_consts.svh"
module port2_port3_pin_function_mux_tb_top;
    logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, port2_irq;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d, p3_in, p3_out, p3_oe, p3_ext = 8'h00;
    logic [5:0] p2_in, p2_out, p2_oe, p2_ext = 6'h00, per = 6'h00, old;
    wire  [4:0] pin_mod;
    logic [31:0] v, e;
    int num_errors = 0, total_checks = 0, seed, flags;
    always #20 sys_clk = ~sys_clk;
    pfm_port_mux i_dut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port2_irq(port2_irq), .port2_pin_in(p2_in), .port2_pin_out(p2_out),
        .port2_pin_oe(p2_oe), .port3_pin_in(p3_in), .port3_pin_out(p3_out),
        .port3_pin_oe(p3_oe), .aux_clock(per[0]), .comparator_result(per[1]),
        .timer_output_unit1(per[2]), .timer_output_unit2(per[3]),
        .serial_transmit_data(per[4]), .serial_shift_clock_out(per[5]),
        .timer_alternate_clock_in(pin_mod[4]), .timer_capture0_alt_input(pin_mod[3]),
        .slave_transmit_enable(pin_mod[2]), .serial_receive_data(pin_mod[1]),
        .serial_shift_clock_in(pin_mod[0]));
    pfm_pin_model i_pins (.p2_out(p2_out), .p2_oe(p2_oe), .p2_ext(p2_ext), .p3_out(p3_out),
        .p3_oe(p3_oe), .p3_ext(p3_ext), .p2_in(p2_in), .p3_in(p3_in));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] w);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe, so sample just after that edge
    task automatic rd(logic [3:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = $urandom(32'hf581);
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        // Reset values, unmapped places read zero
        for (int a = 0; a < 16; a++) begin
            rd(a[3:0]);
            chk(d, 8'h00);
        end
        // Plain I/O with random latches, directions and outside levels
        for (int i = 0; i < 4; i++) begin
            v = $urandom;
            e = $urandom;
            wr(`PFM_OFF_P2_OUT, v[7:0]);
            wr(`PFM_OFF_P2_DIR, v[15:8]);
            wr(`PFM_OFF_P3_OUT, v[23:16]);
            wr(`PFM_OFF_P3_DIR, v[31:24]);
            wr(`PFM_OFF_P2_IN, 8'hff);
            p2_ext <= e[5:0];
            p3_ext <= e[15:8];
            idle(8);
            chk(p2_out, v[5:0]);
            chk(p2_oe, v[13:8]);
            chk(p3_out, v[23:16]);
            chk(p3_oe, v[31:24]);
            chk(pin_mod, 5'h00);
            rd(`PFM_OFF_P2_DIR);
            chk(d, v[15:8]);
            rd(`PFM_OFF_P2_IN);
            chk(d[5:0], (v[5:0] & v[13:8]) | (e[5:0] & ~v[13:8]));
            rd(`PFM_OFF_P3_IN);
            chk(d, (v[23:16] & v[31:24]) | (e[15:8] & ~v[31:24]));
        end
        // All functions selected, each serial mode in turn
        wr(`PFM_OFF_P2_SEL, 8'hff);
        wr(`PFM_OFF_P3_SEL, 8'hff);
        for (int m = 0; m < 3; m++) begin
            v = $urandom;
            wr(`PFM_OFF_SER_MODE, m[7:0]);
            wr(`PFM_OFF_P2_DIR, v[7:0] & 8'hf9);
            wr(`PFM_OFF_P3_DIR, v[15:8]);
            per <= v[21:16];
            p2_ext <= v[27:22];
            p3_ext <= v[31:24];
            idle(8);
            chk(p2_out, {1'b0, per[3], per[2], per[1], 1'b0, per[0]});
            chk(p2_oe, v[5:0] & 6'h39);
            chk(p3_oe, {4'h1, m == 2, v[10:9], 1'b0});
            chk(p3_out & 8'hf7, {3'h0, per[4], 4'h0});
            if (m == 2) chk(p3_out[3], per[5]);
            chk(pin_mod, {p2_ext[1], p2_ext[2], p3_ext[0], p3_ext[5], m != 2 && p3_ext[3]});
        end
        // Edge flags, masking and software flags on the unbonded bits
        wr(`PFM_OFF_P2_SEL, 8'h00);
        wr(`PFM_OFF_P2_DIR, 8'h00);
        idle(8);
        wr(`PFM_OFF_P2_IFG, 8'h00);
        flags = 0;
        for (int i = 0; i < 10; i++) begin
            v = $urandom;
            old = p2_ext;
            wr(`PFM_OFF_P2_IE, v[7:0]);
            wr(`PFM_OFF_P2_IES, v[15:8]);
            p2_ext <= v[21:16];
            flags |= (v[21:16] & ~old & ~v[13:8]) | (~v[21:16] & old & v[13:8]);
            idle(8);
            rd(`PFM_OFF_P2_IFG);
            chk(d, flags[7:0]);
            chk(port2_irq, |(flags[7:0] & v[7:0]));
            wr(`PFM_OFF_P2_IFG, v[31:24]);
            flags = v[31:24];
            idle(2);
            chk(port2_irq, |(flags[7:0] & v[7:0]));
        end
        summarize();
    end
endmodule
